// >>> src/aabd_pkg.sv
// shared constants and types for the add and bit-operation datapath
package aabd_pkg;

   // datapath widths
   localparam int DATA_W    = 8;
   localparam int FADDR_W   = 7;
   localparam int BITIDX_W  = 3;
   localparam int BUS_AW    = 2;

   // one instruction cycle spans this many oscillator periods
   localparam int OSC_PER_INSTR = 4;
   localparam int OSC_PERIOD_NS = 40;

   // nibble boundary used for the digit carry
   localparam int NIB_MSB = 3;

   // register offsets on the software port
   localparam logic [BUS_AW-1:0] REG_ACC_OFS   = 2'h0;
   localparam logic [BUS_AW-1:0] REG_FLAGS_OFS = 2'h1;

   // flag positions inside the flags register
   localparam int FLAG_C_POS  = 0;
   localparam int FLAG_DC_POS = 1;
   localparam int FLAG_Z_POS  = 2;

   // reset values
   localparam logic [DATA_W-1:0] ACC_RST  = 8'h00;
   localparam logic              FLAG_RST = 1'b0;
   localparam logic [DATA_W-1:0] RD_RST   = 8'h00;

   typedef enum logic [2:0] {
      SUM_LITERAL_INTO_ACC  = 3'h0,
      SUM_ACC_AND_FILE      = 3'h1,
      MASK_ACC_WITH_FILE    = 3'h2,
      MASK_ACC_WITH_LITERAL = 3'h3,
      FILE_BIT_CLEAR        = 3'h4,
      FILE_BIT_FORCE_ONE    = 3'h5
   } aabd_op_e;

   // one state per oscillator period of the instruction cycle
   typedef enum logic [3:0] {
      ST_IDLE  = 4'h1,
      ST_READ  = 4'h2,
      ST_EXEC  = 4'h4,
      ST_WRITE = 4'h8
   } aabd_state_e;

endpackage

// >>> src/aabd_datapath.sv
// add, and, bit clear and bit set datapath with accumulator and flags
`timescale 1ns/1ps

// Summary of operation
// - add an 8-bit literal to the accumulator, result to the accumulator, update carry, digit carry and zero.
// - add the accumulator and the addressed file register, result to the chosen destination, update all three flags.
// - destination select 0 writes the accumulator and 1 writes back the addressed file register.
// - and the accumulator with the addressed file register, result to the chosen destination, only zero changes.
// - and the accumulator with an 8-bit literal, result to the accumulator, only zero changes.
// - clear the indexed bit of the addressed file register, other bits and all flags untouched.
// - set the indexed bit of the addressed file register, other bits and all flags untouched.
// - every instruction completes in one instruction cycle of four oscillator periods.
// - a read-modify-write of an I/O port register reads the pin levels, not the output latch.
module aabd_datapath
   import aabd_pkg::*;
#(
   parameter int DW = DATA_W,
   parameter int AW = FADDR_W,
   parameter int BW = BITIDX_W
)(
   input  wire logic            CLK,
   input  wire logic            SYS_RST,
   input  wire logic            OP_VALID,
   output logic                 OP_READY,
   input  wire logic [2:0]      OP_CODE,
   input  wire logic [DW-1:0]   OP_LITERAL,
   input  wire logic [AW-1:0]   OP_FILE_ADDR,
   input  wire logic            OP_DEST,
   input  wire logic [BW-1:0]   OP_BIT_IDX,
   input  wire logic            OP_IS_PORT,
   output logic [AW-1:0]        FILE_ADDR,
   output logic                 FILE_RD_EN,
   input  wire logic [DW-1:0]   FILE_RD_DATA,
   input  wire logic [DW-1:0]   FILE_PIN_DATA,
   output logic                 FILE_WR_EN,
   output logic [DW-1:0]        FILE_WR_DATA,
   output logic [DW-1:0]        ACC_VALUE,
   output logic                 CARRY_FLAG,
   output logic                 NIBBLE_RIPPLE_FLAG,
   output logic                 ZERO_FLAG,
   input  wire logic [BUS_AW-1:0] BUS_ADDR,
   input  wire logic [DW-1:0]   BUS_WDATA,
   input  wire logic            BUS_WR,
   input  wire logic            BUS_RD,
   output logic [DW-1:0]        BUS_RDATA
);

   aabd_state_e     st_q, st_d;
   aabd_op_e        op_q, op_d;
   logic [DW-1:0]   lit_q, lit_d;
   logic [AW-1:0]   fa_q, fa_d;
   logic            dest_q, dest_d;
   logic [BW-1:0]   bit_q, bit_d;
   logic            port_q, port_d;
   logic [DW-1:0]   opnd_q, opnd_d;
   logic [DW-1:0]   res_q, res_d;
   logic            rc_q, rc_d;
   logic            rdc_q, rdc_d;
   logic [DW-1:0]   acc_q, acc_d;
   logic            c_q, c_d;
   logic            dc_q, dc_d;
   logic            z_q, z_d;
   logic [DW-1:0]   rdata_q, rdata_d;

   logic            op_legal;
   logic            is_lit;
   logic            is_add;
   logic            is_bit;
   logic            to_file;
   logic [DW-1:0]   src_b;
   logic [DW:0]     sum9;
   logic [4:0]      nib5;
   logic [DW-1:0]   bmask;

   assign op_legal = (OP_CODE <= 3'(FILE_BIT_FORCE_ONE));
   assign is_lit   = (op_q == SUM_LITERAL_INTO_ACC) || (op_q == MASK_ACC_WITH_LITERAL);
   assign is_add   = (op_q == SUM_LITERAL_INTO_ACC) || (op_q == SUM_ACC_AND_FILE);
   assign is_bit   = (op_q == FILE_BIT_CLEAR) || (op_q == FILE_BIT_FORCE_ONE);
   assign to_file  = is_bit || (dest_q && !is_lit);

   assign src_b = is_lit ? lit_q : opnd_q;
   // carries out of bit 7 and bit 3
   assign sum9  = {1'b0, acc_q} + {1'b0, src_b};
   assign nib5  = {1'b0, acc_q[NIB_MSB:0]} + {1'b0, src_b[NIB_MSB:0]};
   assign bmask = DW'(1) << bit_q;

   // new instructions only in the first period of a cycle
   assign OP_READY     = (st_q == ST_IDLE);
   assign FILE_ADDR    = fa_q;
   assign FILE_RD_EN   = (st_q == ST_READ) && !is_lit;
   assign FILE_WR_EN   = (st_q == ST_WRITE) && to_file;
   assign FILE_WR_DATA = res_q;
   assign ACC_VALUE          = acc_q;
   assign CARRY_FLAG         = c_q;
   assign NIBBLE_RIPPLE_FLAG = dc_q;
   assign ZERO_FLAG          = z_q;
   assign BUS_RDATA          = rdata_q;

   always_comb begin
      st_d    = st_q;
      op_d    = op_q;
      lit_d   = lit_q;
      fa_d    = fa_q;
      dest_d  = dest_q;
      bit_d   = bit_q;
      port_d  = port_q;
      opnd_d  = opnd_q;
      res_d   = res_q;
      rc_d    = rc_q;
      rdc_d   = rdc_q;
      acc_d   = acc_q;
      c_d     = c_q;
      dc_d    = dc_q;
      z_d     = z_q;
      rdata_d = RD_RST;
      case (st_q)
         ST_IDLE: begin
            if (OP_VALID && op_legal) begin
               op_d   = aabd_op_e'(OP_CODE);
               lit_d  = OP_LITERAL;
               fa_d   = OP_FILE_ADDR;
               dest_d = OP_DEST;
               bit_d  = OP_BIT_IDX;
               port_d = OP_IS_PORT;
               st_d   = ST_READ;
            end
         end
         ST_READ: begin
            // port operands come from the pins
            opnd_d = port_q ? FILE_PIN_DATA : FILE_RD_DATA;
            st_d   = ST_EXEC;
         end
         ST_EXEC: begin
            rc_d  = sum9[DW];
            rdc_d = nib5[4];
            case (op_q)
               SUM_LITERAL_INTO_ACC:  res_d = sum9[DW-1:0];
               SUM_ACC_AND_FILE:      res_d = sum9[DW-1:0];
               MASK_ACC_WITH_FILE:    res_d = acc_q & opnd_q;
               MASK_ACC_WITH_LITERAL: res_d = acc_q & lit_q;
               FILE_BIT_CLEAR:        res_d = opnd_q & ~bmask;
               FILE_BIT_FORCE_ONE:    res_d = opnd_q | bmask;
               default:               res_d = res_q;
            endcase
            st_d = ST_WRITE;
         end
         ST_WRITE: begin
            if (!to_file) begin
               acc_d = res_q;
            end
            if (!is_bit) begin
               z_d = (res_q == '0);
            end
            if (is_add) begin
               c_d  = rc_q;
               dc_d = rdc_q;
            end
            st_d = ST_IDLE;
         end
         default: begin
            st_d = ST_IDLE;
         end
      endcase
      // software writes yield to the commit period so flags stay coherent
      if (BUS_WR && (st_q != ST_WRITE)) begin
         case (BUS_ADDR)
            REG_ACC_OFS: begin
               acc_d = BUS_WDATA;
            end
            REG_FLAGS_OFS: begin
               c_d  = BUS_WDATA[FLAG_C_POS];
               dc_d = BUS_WDATA[FLAG_DC_POS];
               z_d  = BUS_WDATA[FLAG_Z_POS];
            end
            default: begin
               acc_d = acc_d;
            end
         endcase
      end
      if (BUS_RD) begin
         case (BUS_ADDR)
            REG_ACC_OFS: begin
               rdata_d = acc_q;
            end
            REG_FLAGS_OFS: begin
               rdata_d[FLAG_C_POS]  = c_q;
               rdata_d[FLAG_DC_POS] = dc_q;
               rdata_d[FLAG_Z_POS]  = z_q;
            end
            default: begin
               rdata_d = RD_RST;
            end
         endcase
      end
   end

   always_ff @(posedge CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         st_q    <= ST_IDLE;
         op_q    <= SUM_LITERAL_INTO_ACC;
         lit_q   <= '0;
         fa_q    <= '0;
         dest_q  <= 1'b0;
         bit_q   <= '0;
         port_q  <= 1'b0;
         opnd_q  <= '0;
         res_q   <= '0;
         rc_q    <= FLAG_RST;
         rdc_q   <= FLAG_RST;
         acc_q   <= ACC_RST;
         c_q     <= FLAG_RST;
         dc_q    <= FLAG_RST;
         z_q     <= FLAG_RST;
         rdata_q <= RD_RST;
      end else begin
         st_q    <= st_d;
         op_q    <= op_d;
         lit_q   <= lit_d;
         fa_q    <= fa_d;
         dest_q  <= dest_d;
         bit_q   <= bit_d;
         port_q  <= port_d;
         opnd_q  <= opnd_d;
         res_q   <= res_d;
         rc_q    <= rc_d;
         rdc_q   <= rdc_d;
         acc_q   <= acc_d;
         c_q     <= c_d;
         dc_q    <= dc_d;
         z_q     <= z_d;
         rdata_q <= rdata_d;
      end
   end

   default clocking cb @(posedge CLK);
   endclocking
   default disable iff (SYS_RST);

   chk_sum_literal: assert property (
      (st_q == ST_EXEC && op_q == SUM_LITERAL_INTO_ACC)
      |=> res_q == DW'($past(acc_q) + lit_q))
      else $error("literal sum wrong");

   chk_sum_file: assert property (
      (st_q == ST_EXEC && op_q == SUM_ACC_AND_FILE)
      |=> res_q == DW'($past(acc_q) + opnd_q) && rc_q == ({1'b0, $past(acc_q)} + {1'b0, opnd_q} > 9'h0FF))
      else $error("file sum or carry wrong");

   chk_dest_file: assert property (
      (st_q == ST_WRITE && !is_lit && dest_q)
      |-> FILE_WR_EN && FILE_WR_DATA == res_q ##1 acc_q == $past(acc_q))
      else $error("file destination not honoured");

   chk_dest_acc: assert property (
      (st_q == ST_WRITE && !is_bit && (is_lit || !dest_q))
      |-> !FILE_WR_EN ##1 acc_q == $past(res_q))
      else $error("accumulator destination not honoured");

   chk_and_flags: assert property (
      (st_q == ST_WRITE && (op_q == MASK_ACC_WITH_FILE || op_q == MASK_ACC_WITH_LITERAL))
      |=> c_q == $past(c_q) && dc_q == $past(dc_q))
      else $error("and changed a carry flag");

   chk_and_literal: assert property (
      (st_q == ST_EXEC && op_q == MASK_ACC_WITH_LITERAL)
      |=> res_q == ($past(acc_q) & lit_q))
      else $error("literal and wrong");

   chk_bit_clear: assert property (
      (st_q == ST_EXEC && op_q == FILE_BIT_CLEAR)
      |=> res_q[bit_q] == 1'b0 && (res_q | bmask) == (opnd_q | bmask))
      else $error("bit clear wrong");

   chk_bit_set: assert property (
      (st_q == ST_EXEC && op_q == FILE_BIT_FORCE_ONE)
      |=> res_q[bit_q] == 1'b1 && (res_q & ~bmask) == (opnd_q & ~bmask))
      else $error("bit set wrong");

   chk_bit_flags: assert property (
      (st_q == ST_WRITE && is_bit)
      |=> {c_q, dc_q, z_q} == $past({c_q, dc_q, z_q}))
      else $error("bit operation changed a flag");

   chk_cycle_len: assert property (
      (OP_VALID && OP_READY && op_legal)
      |=> !OP_READY [*3] ##1 OP_READY)
      else $error("instruction cycle not four periods");

   chk_pin_read: assert property (
      (st_q == ST_READ && port_q)
      |=> opnd_q == $past(FILE_PIN_DATA))
      else $error("port operand not taken from pins");

   chk_zero_flag: assert property (
      (st_q == ST_WRITE && !is_bit)
      |=> z_q == ($past(res_q) == '0))
      else $error("zero flag wrong");

   cov_add_carry: cover property (st_q == ST_WRITE && is_add && rc_q && rdc_q);
   cov_file_dest: cover property (FILE_WR_EN && op_q == SUM_ACC_AND_FILE);
   cov_port_rmw:  cover property (st_q == ST_READ && port_q && is_bit);
   cov_back2back: cover property (st_q == ST_WRITE ##1 (OP_VALID && OP_READY));

endmodule

// >>> verification/aabd_file_model.sv
// behavioural file register space facing the datapath
`timescale 1ns/1ps
module aabd_file_model
   import aabd_pkg::*;
(
   input  wire logic [FADDR_W-1:0] FILE_ADDR,
   input  wire logic               CLK,
   input  wire logic               FILE_RD_EN,
   output logic [DATA_W-1:0]       FILE_RD_DATA,
   output logic [DATA_W-1:0]       FILE_PIN_DATA,
   input  wire logic               FILE_WR_EN,
   input  wire logic [DATA_W-1:0]  FILE_WR_DATA
);
   logic [DATA_W-1:0] mem_q [0:127];
   // released bus shows the inverse, so a late sample is caught
   assign FILE_RD_DATA  = FILE_RD_EN ? mem_q[FILE_ADDR] : ~mem_q[FILE_ADDR];
   // pins pulled against the latch on the low nibble
   assign FILE_PIN_DATA = FILE_RD_EN ? (mem_q[FILE_ADDR] ^ 8'h0F) : ~mem_q[FILE_ADDR];
   always @(posedge CLK) begin
      if (FILE_WR_EN) begin
         mem_q[FILE_ADDR] <= FILE_WR_DATA;
      end
   end
endmodule

// >>> verification/tb.sv
// self-checking bench for the add and bit-operation datapath
`timescale 1ns/1ps
module tb
   import aabd_pkg::*;
;
   logic       CLK = 1'b0, SYS_RST = 1'b1, OP_VALID = 1'b0, OP_DEST = 1'b0, OP_IS_PORT = 1'b0;
   logic       BUS_WR = 1'b0, BUS_RD = 1'b0;
   logic [2:0] OP_CODE = 3'h0, OP_BIT_IDX = 3'h0;
   logic [7:0] OP_LITERAL = 8'h00, BUS_WDATA = 8'h00;
   logic [6:0] OP_FILE_ADDR = 7'h00;
   logic [1:0] BUS_ADDR = 2'h0;
   logic       OP_READY, FILE_RD_EN, FILE_WR_EN, CARRY_FLAG, NIBBLE_RIPPLE_FLAG, ZERO_FLAG;
   logic [6:0] FILE_ADDR;
   logic [7:0] FILE_RD_DATA, FILE_PIN_DATA, FILE_WR_DATA, ACC_VALUE, BUS_RDATA, flg;
   int         mismatches = 0, checks = 0, cyc = 0;
   assign flg = {5'h00, ZERO_FLAG, NIBBLE_RIPPLE_FLAG, CARRY_FLAG};
   always #20 CLK = ~CLK;
   aabd_datapath uut (.CLK, .SYS_RST, .OP_VALID, .OP_READY, .OP_CODE, .OP_LITERAL, .OP_FILE_ADDR,
      .OP_DEST, .OP_BIT_IDX, .OP_IS_PORT, .FILE_ADDR, .FILE_RD_EN, .FILE_RD_DATA, .FILE_PIN_DATA,
      .FILE_WR_EN, .FILE_WR_DATA, .ACC_VALUE, .CARRY_FLAG, .NIBBLE_RIPPLE_FLAG, .ZERO_FLAG,
      .BUS_ADDR, .BUS_WDATA, .BUS_WR, .BUS_RD, .BUS_RDATA);
   aabd_file_model fm (.CLK, .FILE_ADDR, .FILE_RD_EN, .FILE_RD_DATA, .FILE_PIN_DATA,
      .FILE_WR_EN, .FILE_WR_DATA);
   task automatic final_report();
      $display("checks %0d mismatches %0d", checks, mismatches);
      if (mismatches == 0 && checks > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
      checks++;
      if (g !== e) begin
         mismatches++;
         $display("MISMATCH %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic wr(input logic [1:0] a, input logic [7:0] d);
      @(posedge CLK);
      BUS_WR <= 1'b1;
      BUS_ADDR <= a;
      BUS_WDATA <= d;
      @(posedge CLK);
      BUS_WR <= 1'b0;
   endtask
   task automatic rd(input logic [1:0] a, input logic [7:0] e);
      @(posedge CLK);
      BUS_RD <= 1'b1;
      BUS_ADDR <= a;
      @(posedge CLK);
      BUS_RD <= 1'b0;
      #1 chk("bus read", e, BUS_RDATA);
      // read data stands for one cycle only, then falls back to zero
      @(posedge CLK);
      #1 chk("bus idle", 8'h00, BUS_RDATA);
   endtask
   // one instruction: offer, take, then three more periods
   task automatic ex(input logic [2:0] op, input logic [7:0] k, input logic [6:0] f,
                     input logic d, input logic [2:0] b, input logic p);
      @(posedge CLK);
      OP_VALID <= 1'b1;
      OP_CODE <= op;
      OP_LITERAL <= k;
      OP_FILE_ADDR <= f;
      OP_DEST <= d;
      OP_BIT_IDX <= b;
      OP_IS_PORT <= p;
      @(posedge CLK);
      OP_VALID <= 1'b0;
      #1 chk("busy", 8'h00, {7'h00, OP_READY});
      repeat (3) @(posedge CLK);
      #1 chk("ready", 8'h01, {7'h00, OP_READY});
   endtask
   task automatic t_reset();
      chk("acc", 8'h00, ACC_VALUE);
      chk("flags", 8'h00, flg);
      rd(2'h1, 8'h00);
      rd(2'h3, 8'h00);
      $display("test reset done");
   endtask
   task automatic t_add();
      wr(2'h0, 8'h01);
      ex(3'h0, 8'hFF, 7'h00, 1'b1, 3'h0, 1'b0);
      chk("acc", 8'h00, ACC_VALUE);
      chk("flags", 8'h07, flg);
      wr(2'h0, 8'h3A);
      fm.mem_q[5] = 8'h17;
      ex(3'h1, 8'h00, 7'h05, 1'b1, 3'h0, 1'b0);
      chk("file", 8'h51, fm.mem_q[5]);
      chk("acc", 8'h3A, ACC_VALUE);
      chk("flags", 8'h02, flg);
      ex(3'h1, 8'h00, 7'h05, 1'b0, 3'h0, 1'b0);
      chk("acc", 8'h8B, ACC_VALUE);
      chk("file", 8'h51, fm.mem_q[5]);
      chk("flags", 8'h00, flg);
      rd(2'h0, 8'h8B);
      $display("test add done");
   endtask
   task automatic t_and();
      wr(2'h0, 8'hF0);
      wr(2'h1, 8'h03);
      fm.mem_q[127] = 8'h3C;
      ex(3'h2, 8'h00, 7'h7F, 1'b1, 3'h0, 1'b0);
      chk("file", 8'h30, fm.mem_q[127]);
      chk("acc", 8'hF0, ACC_VALUE);
      chk("flags", 8'h03, flg);
      ex(3'h2, 8'h00, 7'h7F, 1'b0, 3'h0, 1'b0);
      chk("acc", 8'h30, ACC_VALUE);
      ex(3'h3, 8'h0F, 7'h00, 1'b1, 3'h0, 1'b0);
      chk("acc", 8'h00, ACC_VALUE);
      chk("flags", 8'h07, flg);
      $display("test and done");
   endtask
   task automatic t_bits();
      fm.mem_q[64] = 8'hFF;
      for (int i = 0; i < 8; i++) begin
         ex(3'h4, 8'h00, 7'h40, 1'b0, 3'(i), 1'b0);
         chk("bit clear", 8'hFF << (i + 1), fm.mem_q[64]);
      end
      for (int i = 0; i < 8; i++) begin
         ex(3'h5, 8'h00, 7'h40, 1'b0, 3'(i), 1'b0);
         chk("bit set", ~(8'hFF << (i + 1)), fm.mem_q[64]);
      end
      chk("flags", 8'h07, flg);
      chk("acc", 8'h00, ACC_VALUE);
      $display("test bits done");
   endtask
   task automatic t_port();
      wr(2'h0, 8'h01);
      fm.mem_q[9] = 8'h55;
      ex(3'h1, 8'h00, 7'h09, 1'b1, 3'h0, 1'b1);
      chk("port file", 8'h5B, fm.mem_q[9]);
      chk("flags", 8'h00, flg);
      ex(3'h5, 8'h00, 7'h09, 1'b0, 3'h7, 1'b1);
      chk("port bit", 8'hD4, fm.mem_q[9]);
      chk("flags", 8'h00, flg);
      chk("acc", 8'h01, ACC_VALUE);
      $display("test port done");
   endtask
   task automatic t_illegal();
      for (int i = 6; i < 8; i++) begin
         @(posedge CLK);
         OP_VALID <= 1'b1;
         OP_CODE <= 3'(i);
         repeat (2) @(posedge CLK);
         OP_VALID <= 1'b0;
         #1 chk("ready", 8'h01, {7'h00, OP_READY});
         chk("acc", 8'h01, ACC_VALUE);
      end
      $display("test illegal done");
   endtask
   // valid held high, so the second offer is taken in the idle period right after the commit
   task automatic t_b2b();
      wr(2'h0, 8'hF0);
      @(posedge CLK);
      OP_VALID <= 1'b1;
      OP_CODE <= 3'h0;
      OP_LITERAL <= 8'h10;
      repeat (4) @(posedge CLK);
      OP_LITERAL <= 8'h0F;
      #1 chk("acc", 8'h00, ACC_VALUE);
      chk("flags", 8'h05, flg);
      @(posedge CLK);
      OP_VALID <= 1'b0;
      repeat (4) @(posedge CLK);
      #1 chk("acc", 8'h0F, ACC_VALUE);
      chk("flags", 8'h00, flg);
      $display("test back to back done");
   endtask
   // hang guard, well above the 165 or so cycles needed
   always @(posedge CLK) begin
      cyc++;
      if (cyc == 3000) begin
         mismatches++;
         final_report();
      end
   end
   initial begin
      repeat (8) @(posedge CLK);
      SYS_RST <= 1'b0;
      t_reset();
      t_add();
      t_and();
      t_bits();
      t_port();
      t_illegal();
      t_b2b();
      final_report();
   end
endmodule
